// ---- hw/psa_top.sv ----
// Power state, annunciation and front I/O control
`timescale 1ns/100ps
module psa_top
  import psa_pkg::*;
#(
  parameter int unsigned INIT_CYCLES     = INIT_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned SAMPLE_CYCLES   = SAMPLE_CYC,
  parameter int unsigned SHORT_CYCLES    = BEEP_SHORT_CYC,
  parameter int unsigned LONG_CYCLES     = BEEP_LONG_CYC,
  parameter int unsigned GAP_CYCLES      = BEEP_GAP_CYC
) (
  input  wire logic                CORE_CLK,
  input  wire logic                RST,
  input  wire logic                POWER_BTN_N,
  input  wire logic                REMOTE_BTN_N,
  input  wire logic                IGNITION_SENSE_INPUT,
  input  wire logic                BEEP_ENABLE,
  input  wire logic                READY_EVT,
  input  wire logic                MEAS_DONE_EVT,
  input  wire logic                ERROR_EVT,
  input  wire logic                PORT_OVERLOAD,
  input  wire logic                SAVE_DONE,
  input  wire logic [NUM_TRIG-1:0] TRIG_IN,
  input  wire logic [NUM_LED-1:0]  LED_STATE,
  input  wire logic [NUM_GPO-1:0]  APP_GPO,
  output logic                     BEEP,
  output logic                     STATUS_OUT,
  output logic                     PORTS_EN,
  output logic                     ABORT_REQ,
  output logic                     SAVE_REQ,
  output logic                     ERROR_IND,
  output logic [NUM_TRIG-1:0]      TRIG_SAMPLED,
  output logic [NUM_LED-1:0]       LED_MIRROR,
  output logic [NUM_GPO-1:0]       GPO
);

  localparam logic [CNT_W-1:0] DEB_MAX  = CNT_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SAMP_MAX = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] INIT_MAX = CNT_W'(INIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] SHRT_MAX = CNT_W'(SHORT_CYCLES - 1);
  localparam logic [CNT_W-1:0] LONG_MAX = CNT_W'(LONG_CYCLES - 1);
  localparam logic [CNT_W-1:0] GAP_MAX  = CNT_W'(GAP_CYCLES - 1);

  // Two-stage synchronisers for the button, ignition and trigger inputs
  logic [2:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
    end
    else
    begin
      pin_s1_q <= {IGNITION_SENSE_INPUT, REMOTE_BTN_N, POWER_BTN_N};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic [NUM_TRIG-1:0] trig_s1_q, trig_s2_q;
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      trig_s1_q <= '0;
      trig_s2_q <= '0;
    end
    else
    begin
      trig_s1_q <= TRIG_IN;
      trig_s2_q <= trig_s1_q;
    end
  end

  // Debounce: level accepted only after holding for the full window
  logic [2:0]       deb_q, deb_prev_q;
  logic [CNT_W-1:0] deb_cnt_q [3];
  for (genvar i = 0; i < 3; i++)
  begin : g_deb
    always_ff @(posedge CORE_CLK)
    begin
      if (RST)
      begin
        deb_q[i]     <= 1'b1;
        deb_cnt_q[i] <= '0;
      end
      else if (pin_s2_q[i] == deb_q[i])
        deb_cnt_q[i] <= '0;
      else if (deb_cnt_q[i] == DEB_MAX)
      begin
        deb_q[i]     <= pin_s2_q[i];
        deb_cnt_q[i] <= '0;
      end
      else
        deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      deb_prev_q <= 3'h7;
    else
      deb_prev_q <= deb_q;
  end

  logic press, ign_rise, ign_fall;
  // Low-active buttons share one press path
  assign press    = (deb_prev_q[0] & ~deb_q[0]) | (deb_prev_q[1] & ~deb_q[1]);
  // Ignition resets to high so a high line at power-up yields no spurious rise
  assign ign_rise = ~deb_prev_q[2] & deb_q[2];
  assign ign_fall = deb_prev_q[2] & ~deb_q[2];

  // Power state machine
  psa_state_t       state_q;
  logic [CNT_W-1:0] init_cnt_q;
  logic             init_done;
  assign init_done = (state_q == PSA_INIT) && (init_cnt_q == INIT_MAX);

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      init_cnt_q <= '0;
    else if (state_q == PSA_INIT && !init_done)
      init_cnt_q <= init_cnt_q + 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      state_q <= PSA_INIT;
    else
      case (state_q)
        PSA_INIT:
          if (init_done)
            state_q <= PSA_STANDBY;
        PSA_STANDBY:
          if (press || ign_rise)
            state_q <= PSA_RUN;
        PSA_RUN:
          if (PORT_OVERLOAD)
            state_q <= PSA_ABORT;
          else if (press || ign_fall)
            state_q <= PSA_STANDBY;
        PSA_ABORT:
          state_q <= PSA_SAVE;
        PSA_SAVE:
          if (SAVE_DONE)
            state_q <= PSA_EOFF;
        PSA_EOFF:
          state_q <= PSA_STANDBY;
        default:
          state_q <= PSA_INIT;
      endcase
  end

  // Overload step outputs
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      PORTS_EN   <= 1'b0;
      ABORT_REQ  <= 1'b0;
      SAVE_REQ   <= 1'b0;
      STATUS_OUT <= 1'b0;
    end
    else
    begin
      PORTS_EN   <= (state_q == PSA_RUN) && !PORT_OVERLOAD;
      ABORT_REQ  <= (state_q == PSA_ABORT);
      SAVE_REQ   <= (state_q == PSA_SAVE);
      // Still on while aborting and saving; off in init, standby and emergency off
      STATUS_OUT <= (state_q == PSA_RUN) || (state_q == PSA_ABORT)
                    || (state_q == PSA_SAVE);
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      ERROR_IND <= 1'b0;
    else if (state_q == PSA_EOFF)
      ERROR_IND <= 1'b1;
    else if (press)
      ERROR_IND <= 1'b0;
  end

  // Beep sequencer; a new request is ignored while a pattern plays
  logic             err_start;
  logic             beep_req;
  logic [2:0]       req_n;
  logic             req_long;
  logic [2:0]       beeps_q;
  logic             long_q, on_q;
  logic [CNT_W-1:0] bcnt_q;
  logic             busy;
  assign busy      = (beeps_q != 3'h0);
  assign err_start = ERROR_EVT || (state_q == PSA_EOFF);
  always_comb
  begin
    beep_req = 1'b1;
    req_long = 1'b0;
    req_n    = NBEEP_PRESS;
    if (err_start)
    begin
      req_long = 1'b1;
      req_n    = NBEEP_ONE;
    end
    else if (press && state_q != PSA_INIT)
      req_n = NBEEP_PRESS;
    else if (init_done)
      req_n = NBEEP_ONE;
    else if (READY_EVT)
      req_n = NBEEP_READY;
    else if (MEAS_DONE_EVT)
      req_n = NBEEP_DONE;
    else
      beep_req = 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      beeps_q <= 3'h0;
      long_q  <= 1'b0;
      on_q    <= 1'b0;
      bcnt_q  <= '0;
    end
    else if (!busy)
    begin
      if (beep_req && BEEP_ENABLE)
      begin
        beeps_q <= req_n;
        long_q  <= req_long;
        on_q    <= 1'b1;
        bcnt_q  <= '0;
      end
    end
    else if (on_q && bcnt_q == (long_q ? LONG_MAX : SHRT_MAX))
    begin
      on_q    <= 1'b0;
      bcnt_q  <= '0;
      beeps_q <= beeps_q - 3'h1;
    end
    else if (!on_q && bcnt_q == GAP_MAX)
    begin
      on_q   <= 1'b1;
      bcnt_q <= '0;
    end
    else
      bcnt_q <= bcnt_q + 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      BEEP <= 1'b0;
    else
      BEEP <= BEEP_ENABLE && on_q && busy;
  end

  // Trigger sampling at the slow rate
  logic [CNT_W-1:0] samp_cnt_q;
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      samp_cnt_q   <= '0;
      TRIG_SAMPLED <= '0;
    end
    else if (samp_cnt_q == SAMP_MAX)
    begin
      samp_cnt_q   <= '0;
      TRIG_SAMPLED <= trig_s2_q;
    end
    else
      samp_cnt_q <= samp_cnt_q + 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      LED_MIRROR <= '0;
      GPO        <= '0;
    end
    else
    begin
      LED_MIRROR <= LED_STATE;
      GPO        <= APP_GPO;
    end
  end

  a_status_run: assert property (@(posedge CORE_CLK) disable iff (RST)
    1 |=> STATUS_OUT == ($past(state_q) == PSA_RUN || $past(state_q) == PSA_ABORT
                         || $past(state_q) == PSA_SAVE))
    else $error("status output does not follow run state");
  a_mute_beep: assert property (@(posedge CORE_CLK) disable iff (RST)
    !BEEP_ENABLE |=> !BEEP)
    else $error("beep while disabled");
  a_press_toggle: assert property (@(posedge CORE_CLK) disable iff (RST)
    (press && state_q == PSA_STANDBY) |=> state_q == PSA_RUN)
    else $error("press did not start device");
  a_ign_fall: assert property (@(posedge CORE_CLK) disable iff (RST)
    (ign_fall && !press && !PORT_OVERLOAD && state_q == PSA_RUN)
      |=> state_q == PSA_STANDBY)
    else $error("ignition fall did not shut down");
  sequence s_abort_save;
    ABORT_REQ ##1 SAVE_REQ;
  endsequence
  a_overload_seq: assert property (@(posedge CORE_CLK) disable iff (RST)
    (state_q == PSA_RUN && PORT_OVERLOAD) |=> ##1 s_abort_save)
    else $error("overload sequence out of order");
  a_ports_off: assert property (@(posedge CORE_CLK) disable iff (RST)
    PORT_OVERLOAD |=> !PORTS_EN)
    else $error("ports stay on under overload");
  a_led_mirror: assert property (@(posedge CORE_CLK) disable iff (RST)
    1 |=> LED_MIRROR == $past(LED_STATE))
    else $error("indicator mirror mismatch");
  a_sample_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    (samp_cnt_q != SAMP_MAX) |=> $stable(TRIG_SAMPLED))
    else $error("trigger sampled too often");
  a_gpo_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
    1 |=> GPO == $past(APP_GPO))
    else $error("general output mismatch");

endmodule : psa_top

// ---- hw/psa_pkg.sv ----
// Constants and types for the power state annunciator
package psa_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned BEEP_SHORT_MS   = 500;
  localparam int unsigned BEEP_LONG_MS    = 2000;
  localparam int unsigned BEEP_GAP_MS     = 500;
  localparam int unsigned INIT_MS         = 3000;
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned SAMPLE_HZ       = 10;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned BEEP_SHORT_CYC  = BEEP_SHORT_MS * CYC_PER_MS;
  localparam int unsigned BEEP_LONG_CYC   = BEEP_LONG_MS * CYC_PER_MS;
  localparam int unsigned BEEP_GAP_CYC    = BEEP_GAP_MS * CYC_PER_MS;
  localparam int unsigned INIT_CYC        = INIT_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;
  // Least period at the highest allowed rate, rounded up
  localparam int unsigned SAMPLE_CYC      = (CLK_HZ + SAMPLE_HZ - 1) / SAMPLE_HZ;
  localparam int unsigned CNT_W           = 26;
  localparam int unsigned NUM_TRIG        = 4;
  localparam int unsigned NUM_LED         = 6;
  localparam int unsigned NUM_GPO         = 4;
  localparam logic [2:0]  NBEEP_PRESS     = 3'h1;
  localparam logic [2:0]  NBEEP_READY     = 3'h2;
  localparam logic [2:0]  NBEEP_DONE      = 3'h3;
  localparam logic [2:0]  NBEEP_ONE       = 3'h1;

  typedef enum logic [2:0] {
    PSA_INIT    = 3'b000,
    PSA_STANDBY = 3'b001,
    PSA_RUN     = 3'b011,
    PSA_ABORT   = 3'b010,
    PSA_SAVE    = 3'b110,
    PSA_EOFF    = 3'b111
  } psa_state_t;
endpackage : psa_pkg

// ---- dv/psa_far_side.sv ----
// Far-side model: front button, remote button and ignition line
`timescale 1ns/100ps
module psa_far_side (
  input  wire logic clk,
  output logic      pwr_btn_n,
  output logic      rem_btn_n,
  output logic      ign
);
  initial
  begin
    pwr_btn_n = 1'b1;
    rem_btn_n = 1'b1;
    ign       = 1'b0;
  end

  // Contacts chatter first, then settle long past the debounce span
  task automatic drive(input int sel, input logic v);
    logic b;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk);
      b = (i < 4) ? (~v ^ i[0]) : v;
      case (sel)
        0: pwr_btn_n <= b;
        1: rem_btn_n <= b;
        default: ign <= b;
      endcase
    end
  endtask : drive

  // Press pulls the contact to ground, release lets the pull-up win
  task automatic press(input int sel);
    drive(sel, 1'b0);
    drive(sel, 1'b1);
  endtask : press
endmodule : psa_far_side

// ---- dv/test_psa_top.sv ----
// Self-checking bench for the power state annunciator
`timescale 1ns/100ps
module test_psa_top
  import psa_pkg::*;
;
  logic                core_clk;
  logic                rst;
  logic                beep_en;
  logic [2:0]          evt;
  logic                ovl;
  logic                save_done;
  logic [NUM_TRIG-1:0] trig;
  logic [NUM_LED-1:0]  led;
  logic [NUM_GPO-1:0]  gpo_in;
  wire  logic          pwr_n;
  wire  logic          rem_n;
  wire  logic          ign;
  logic                beep;
  logic                status;
  logic                ports_en;
  logic                abort_req;
  logic                save_req;
  logic                err_ind;
  logic [NUM_TRIG-1:0] trig_s;
  logic [NUM_LED-1:0]  led_m;
  logic [NUM_GPO-1:0]  gpo;
  int                  mismatches;
  int                  n_compared;
  int                  seed = 32'h62a8bc95;
  int                  beep_len;
  int                  beeps[$];
  int                  t[5];
  logic [4:0]          seen5;
  int                  exp_n[3] = '{2, 3, 1};
  int                  exp_l[3] = '{5, 5, 20};

  psa_top #(.INIT_CYCLES(50), .DEBOUNCE_CYCLES(4), .SAMPLE_CYCLES(10),
    .SHORT_CYCLES(5), .LONG_CYCLES(20), .GAP_CYCLES(5)) dut (
    .CORE_CLK(core_clk), .RST(rst), .POWER_BTN_N(pwr_n), .REMOTE_BTN_N(rem_n),
    .IGNITION_SENSE_INPUT(ign), .BEEP_ENABLE(beep_en), .READY_EVT(evt[0]),
    .MEAS_DONE_EVT(evt[1]), .ERROR_EVT(evt[2]), .PORT_OVERLOAD(ovl),
    .SAVE_DONE(save_done), .TRIG_IN(trig), .LED_STATE(led), .APP_GPO(gpo_in),
    .BEEP(beep), .STATUS_OUT(status), .PORTS_EN(ports_en), .ABORT_REQ(abort_req),
    .SAVE_REQ(save_req), .ERROR_IND(err_ind), .TRIG_SAMPLED(trig_s),
    .LED_MIRROR(led_m), .GPO(gpo));

  psa_far_side far (.clk(core_clk), .pwr_btn_n(pwr_n), .rem_btn_n(rem_n), .ign(ign));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Reference beep record: length of every tone heard
  always @(posedge core_clk)
    if (beep === 1'b1)
      beep_len++;
    else if (beep_len > 0)
    begin
      beeps.push_back(beep_len);
      beep_len = 0;
    end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic expect_beeps(input int n, input int len);
    repeat (60) @(posedge core_clk);
    check(beeps.size(), n);
    foreach (beeps[i]) check(beeps[i], len);
    beeps.delete();
  endtask : expect_beeps

  task automatic fire(input int k);
    @(posedge core_clk);
    evt <= 3'h1 << k;
    @(posedge core_clk);
    evt <= 3'h0;
  endtask : fire

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    {rst, beep_en, evt, ovl, save_done, trig, led, gpo_in} = '0;
    rst = 1'b1;
    beep_en = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 check({status, ports_en, beep, err_ind}, 4'h0);
    @(posedge core_clk) rst <= 1'b0;
    beeps.delete();
    repeat (40) @(posedge core_clk);
    expect_beeps(1, 5);
    check(status, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      led <= NUM_LED'($random(seed));
      gpo_in <= NUM_GPO'($random(seed));
      trig <= NUM_TRIG'($random(seed));
      ovl <= 1'($random(seed));
      beep_en <= 1'($random(seed));
      @(posedge core_clk) #1;
      check(led_m, led);
      check(gpo, gpo_in);
      repeat (30) @(posedge core_clk);
      #1 check(trig_s, trig);
    end
    ovl <= 1'b0;
    beep_en <= 1'b1;
    far.press(0);
    check({status, ports_en}, 2'h3);
    expect_beeps(1, 5);
    for (int k = 0; k < 3; k++)
    begin
      fire(k);
      expect_beeps(exp_n[k], exp_l[k]);
    end
    beep_en <= 1'b0;
    fire(0);
    fire(2);
    expect_beeps(0, 0);
    beep_en <= 1'b1;
    far.press(1);
    check(status, 1'b0);
    far.drive(2, 1'b1);
    check(status, 1'b1);
    far.drive(2, 1'b0);
    check(status, 1'b0);
    far.drive(2, 1'b1);
    check(status, 1'b1);
    repeat (60) @(posedge core_clk);
    beeps.delete();
    t = '{-1, -1, -1, -1, -1};
    @(posedge core_clk) ovl <= 1'b1;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge core_clk) #1;
      seen5 = {err_ind, !status, save_req, abort_req, !ports_en};
      foreach (t[j])
        if (t[j] < 0 && seen5[j])
          t[j] = i;
      if (save_req)
        save_done <= save_done | 1'($random(seed));
    end
    ovl <= 1'b0;
    save_done <= 1'b0;
    check(t[0] >= 0 && t[0] <= t[1] && t[1] <= t[2], 1'b1);
    check(t[2] < t[3] && t[3] <= t[4], 1'b1);
    check({err_ind, status, ports_en}, 3'h4);
    expect_beeps(1, 20);
    report_and_stop();
  end
endmodule : test_psa_top
